// File: pkg/byte_if.sv
// byte request channel between sequencer and byte writer
`default_nettype none
interface byte_if;
	logic valid;
	logic ready;
	logic dc;
	logic [7:0] data;
	modport src (output valid, output dc, output data, input ready);
	modport dst (input valid, input dc, input data, output ready);
endinterface : byte_if
`default_nettype wire

// File: pkg/oled_seq_pkg.sv
// constants and types for the display power and initialisation sequencer
// How it works
// - hold panel reset low at least 3us
// - wait 3us after reset low, then panel supply
// - display-on command after panel supply stable
// - power down: display-off before panel supply off
// - logic supply off at least 80ms later
// - logic supply never off while panel on
// - clock setting command then 105Hz byte
// - multiplex command then 1/64 duty byte
// - offset, start line, remap, scan, pin config
// - contrast command with 0x80
// - precharge, deselect level, resume, normal display
// - clear eight pages of 128 zero bytes
// - start with display-off, end with display-on
`default_nettype none
package oled_seq_pkg;
	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLK_HZ = 50_000_000;
	localparam int RESET_PULSE_TIME_NS = 3000;
	localparam int RESET_TO_PANEL_SUPPLY_DELAY_NS = 3000;
	localparam int DRIVER_ON_DELAY_MS = 100;
	localparam int OFF_DELAY_MIN_MS = 80;
	localparam int OFF_DELAY_TYP_MS = 100;
	localparam int SUPPLY_SETTLE_MS = 1;
	// least times round up
	localparam int RESET_PULSE_CYC = (RESET_PULSE_TIME_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
	localparam int PANEL_DELAY_CYC =
		(RESET_TO_PANEL_SUPPLY_DELAY_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
	localparam int DRIVER_ON_CYC = DRIVER_ON_DELAY_MS * (CLK_HZ / 1000);
	localparam int OFF_DELAY_CYC = OFF_DELAY_TYP_MS * (CLK_HZ / 1000);
	localparam int SETTLE_CYC = SUPPLY_SETTLE_MS * (CLK_HZ / 1000);
	// ----------------------------------------------------------------
	// commands
	// ----------------------------------------------------------------
	localparam logic [7:0] CMD_DISPLAY_OFF = 8'hAE;
	localparam logic [7:0] CMD_DISPLAY_ON = 8'hAF;
	localparam logic [7:0] CMD_PAGE_BASE = 8'hB0;
	localparam logic [7:0] CMD_COL_LOW = 8'h00;
	localparam logic [7:0] CMD_COL_HIGH = 8'h10;
	localparam logic [7:0] CLEAR_BYTE = 8'h00;
	localparam int INIT_LEN = 20;
	localparam int PAGES = 8;
	localparam int COLUMNS = 128;
	localparam logic [7:0] INIT_TABLE [INIT_LEN] = '{
		8'hAE, 8'hD5, 8'hA0, 8'hA8, 8'h3F, 8'hD3, 8'h00, 8'h40, 8'hA1, 8'hC8,
		8'hDA, 8'h12, 8'h81, 8'h80, 8'hD9, 8'h22, 8'hDB, 8'h3C, 8'hA4, 8'hA6};
	typedef enum logic [4:0] {
		ST_OFF, ST_VDD_SETTLE, ST_RESET_LOW, ST_PANEL_WAIT, ST_INIT, ST_PAGE,
		ST_COL_LO, ST_COL_HI, ST_CLEAR, ST_VCC_SETTLE, ST_ON_CMD, ST_DRV_WAIT,
		ST_READY, ST_OFF_CMD, ST_VCC_OFF, ST_OFF_WAIT
	} seq_state_e;
endpackage : oled_seq_pkg
`default_nettype wire

// File: rtl/byte_writer.sv
// parallel write strobe generator for one byte at a time
`default_nettype none
module byte_writer #(
	parameter int STROBE_CYC = 4
) (
	input wire logic clk,
	input wire logic resetn,
	byte_if.dst req,
	output logic wr_n,
	output logic dc,
	output logic [7:0] data
);
	import oled_seq_pkg::*;
	logic [3:0] cnt_r;
	logic busy_r;
	// idle takes a byte, then holds it for a low and a high phase of the strobe
	assign req.ready = !busy_r;
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			busy_r <= 1'b0;
			cnt_r <= 4'h0;
			wr_n <= 1'b1;
			dc <= 1'b0;
			data <= 8'h00;
		end else if (!busy_r) begin
			if (req.valid) begin
				busy_r <= 1'b1;
				cnt_r <= 4'h0;
				dc <= req.dc;
				data <= req.data;
				wr_n <= 1'b0;
			end
		end else begin
			cnt_r <= cnt_r + 4'h1;
			if (cnt_r == 4'(STROBE_CYC - 1))
				wr_n <= 1'b1;
			if (cnt_r == 4'(2 * STROBE_CYC - 1))
				busy_r <= 1'b0;
		end
	end
endmodule : byte_writer
`default_nettype wire

// File: rtl/oled_power_init_sequencer.sv
// host sequencer: supplies, reset pulse, init commands, ram clear, power down
`default_nettype none
module oled_power_init_sequencer #(
	parameter int DRIVER_ON_CYCLES = oled_seq_pkg::DRIVER_ON_CYC,
	parameter int OFF_DELAY_CYCLES = oled_seq_pkg::OFF_DELAY_CYC,
	parameter int SETTLE_CYCLES = oled_seq_pkg::SETTLE_CYC
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic power_up,
	input wire logic power_down,
	output logic vdd_en,
	output logic vcc_en,
	output logic panel_reset_low_n,
	output logic wr_n,
	output logic dc,
	output logic [7:0] data,
	output logic ready,
	output logic busy
);
	import oled_seq_pkg::*;
	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	seq_state_e state_r;
	// wide enough for the 100ms waits at the full clock rate
	logic [23:0] timer_r;
	logic [4:0] idx_r;
	logic [2:0] page_r;
	logic [6:0] col_r;
	logic timer_done;
	logic send;
	byte_if bus ();
	assign timer_done = (timer_r == 24'h000000);
	assign ready = (state_r == ST_READY);
	assign busy = (state_r != ST_READY) && (state_r != ST_OFF);

	// ----------------------------------------------------------------
	// byte source
	// ----------------------------------------------------------------
	always_comb begin
		bus.valid = 1'b0;
		bus.dc = 1'b0;
		bus.data = 8'h00;
		unique case (state_r)
			ST_INIT: begin
				bus.valid = 1'b1;
				bus.data = INIT_TABLE[idx_r];
			end
			ST_PAGE: begin
				bus.valid = 1'b1;
				bus.data = CMD_PAGE_BASE + {5'h00, page_r};
			end
			ST_COL_LO: begin
				bus.valid = 1'b1;
				bus.data = CMD_COL_LOW;
			end
			ST_COL_HI: begin
				bus.valid = 1'b1;
				bus.data = CMD_COL_HIGH;
			end
			ST_CLEAR: begin
				bus.valid = 1'b1;
				bus.dc = 1'b1;
				bus.data = CLEAR_BYTE;
			end
			ST_ON_CMD: begin
				bus.valid = 1'b1;
				bus.data = CMD_DISPLAY_ON;
			end
			ST_OFF_CMD: begin
				bus.valid = 1'b1;
				bus.data = CMD_DISPLAY_OFF;
			end
			default: begin
				bus.valid = 1'b0;
			end
		endcase
	end
	// a byte moves on the cycle both sides agree
	assign send = bus.valid && bus.ready;

	// ----------------------------------------------------------------
	// sequence
	// ----------------------------------------------------------------
	// the timer counts down by itself; states only reload it
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state_r <= ST_OFF;
			timer_r <= 24'h000000;
			idx_r <= 5'h00;
			page_r <= 3'h0;
			col_r <= 7'h00;
		end else begin
			if (!timer_done)
				timer_r <= timer_r - 24'h000001;
			unique case (state_r)
				ST_OFF: if (power_up) begin
					state_r <= ST_VDD_SETTLE;
					timer_r <= 24'(SETTLE_CYCLES - 1);
				end
				ST_VDD_SETTLE: if (timer_done) begin
					state_r <= ST_RESET_LOW;
					timer_r <= 24'(RESET_PULSE_CYC - 1);
				end
				ST_RESET_LOW: if (timer_done) begin
					// reset released after the pulse, device registers now default
					state_r <= ST_PANEL_WAIT;
					timer_r <= 24'(PANEL_DELAY_CYC - 1);
				end
				ST_PANEL_WAIT: if (timer_done) begin
					state_r <= ST_INIT;
					idx_r <= 5'h00;
				end
				ST_INIT: if (send) begin
					if (idx_r == 5'(INIT_LEN - 1)) begin
						state_r <= ST_PAGE;
						page_r <= 3'h0;
					end else
						idx_r <= idx_r + 5'h01;
				end
				ST_PAGE: if (send)
					state_r <= ST_COL_LO;
				ST_COL_LO: if (send)
					state_r <= ST_COL_HI;
				ST_COL_HI: if (send) begin
					state_r <= ST_CLEAR;
					col_r <= 7'h00;
				end
				ST_CLEAR: if (send) begin
					// column wraps with the page, one full row of zeros per page
					col_r <= col_r + 7'h01;
					if (col_r == 7'(COLUMNS - 1)) begin
						if (page_r == 3'(PAGES - 1)) begin
							state_r <= ST_VCC_SETTLE;
							timer_r <= 24'(SETTLE_CYCLES - 1);
						end else begin
							page_r <= page_r + 3'h1;
							state_r <= ST_PAGE;
						end
					end
				end
				// no supply-good input, so a fixed settle time stands in for it
				ST_VCC_SETTLE: if (timer_done)
					state_r <= ST_ON_CMD;
				ST_ON_CMD: if (send) begin
					state_r <= ST_DRV_WAIT;
					timer_r <= 24'(DRIVER_ON_CYCLES - 1);
				end
				ST_DRV_WAIT: begin
					// the panel latches display-on at the strobe end; count from when the writer frees up, after its high phase
					if (!bus.ready)
						timer_r <= 24'(DRIVER_ON_CYCLES - 1);
					else if (timer_done)
						state_r <= ST_READY;
				end
				ST_READY: if (power_down)
					state_r <= ST_OFF_CMD;
				ST_OFF_CMD: if (send)
					state_r <= ST_VCC_OFF;
				ST_VCC_OFF: if (bus.ready) begin
					// wait for the strobe to finish before dropping the panel supply
					state_r <= ST_OFF_WAIT;
					timer_r <= 24'(OFF_DELAY_CYCLES - 1);
				end
				ST_OFF_WAIT: if (timer_done)
					state_r <= ST_OFF;
				default: state_r <= ST_OFF;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// supply and reset decode
	// ----------------------------------------------------------------
	// panel supply spans the first init byte up to the finished display-off strobe
	function automatic logic panel_supply_on(input seq_state_e s);
		return s inside {ST_INIT, ST_PAGE, ST_COL_LO, ST_COL_HI, ST_CLEAR, ST_VCC_SETTLE,
			ST_ON_CMD, ST_DRV_WAIT, ST_READY, ST_OFF_CMD, ST_VCC_OFF};
	endfunction : panel_supply_on
	// reset pin stays low from power off through the full pulse
	function automatic logic reset_asserted(input seq_state_e s);
		return s inside {ST_OFF, ST_VDD_SETTLE, ST_RESET_LOW};
	endfunction : reset_asserted

	// ----------------------------------------------------------------
	// supplies and reset pin
	// ----------------------------------------------------------------
	// logic supply only drops from the final wait, after panel supply is off
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			vdd_en <= 1'b0;
		end else begin
			vdd_en <= (state_r != ST_OFF) && !(state_r == ST_OFF_WAIT && timer_done);
		end
	end
	// registered, so the supply edge lands one clock after the state that asks for it
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			vcc_en <= 1'b0;
		end else begin
			vcc_en <= panel_supply_on(state_r);
		end
	end
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			panel_reset_low_n <= 1'b0;
		end else begin
			panel_reset_low_n <= !reset_asserted(state_r);
		end
	end

	byte_writer byte_writer_i (
		.clk(clk),
		.resetn(resetn),
		.req(bus),
		.wr_n(wr_n),
		.dc(dc),
		.data(data)
	);
endmodule : oled_power_init_sequencer
`default_nettype wire

// File: verif/oled_panel_model.sv
// behavioural display module driven by the sequencer's pins
`default_nettype none
module oled_panel_model #(
	parameter int ON_DELAY = 20
) (
	input wire logic clk,
	input wire logic vdd_en,
	input wire logic panel_reset_low_n,
	input wire logic wr_n,
	input wire logic dc,
	input wire logic [7:0] data,
	output logic drivers_on
);
	timeunit 1ns;
	timeprecision 1ps;
	int on_cnt = -1;
	initial drivers_on = 1'b0;
	// drivers wait a fixed spell after display-on, so an early ready shows up
	always @(posedge wr_n) if (vdd_en && panel_reset_low_n && !dc) begin
		if (data == 8'hAF) on_cnt = ON_DELAY;
		if (data == 8'hAE) on_cnt = -1;
		if (data == 8'hAE) drivers_on = 1'b0;
	end
	always @(posedge clk) begin
		if (!vdd_en || !panel_reset_low_n) begin
			on_cnt = -1;
			drivers_on = 1'b0;
		end else if (on_cnt > 0) on_cnt--;
		else if (on_cnt == 0) drivers_on = 1'b1;
	end
endmodule : oled_panel_model
`default_nettype wire

// File: verif/oled_power_init_sequencer_test.sv
// self-checking bench for the display power and initialisation sequencer
`default_nettype none
module oled_power_init_sequencer_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 0, resetn = 0, power_up = 0, power_down = 0;
	logic vdd_en, vcc_en, panel_reset_low_n, wr_n, dc, ready, busy, drivers_on;
	logic [7:0] data;
	logic [8:0] exp_q[$];
	int failures = 0, n_checks = 0;
	logic [31:0] seed = 32'h1D;
	initial forever #10 clk = ~clk;
	oled_power_init_sequencer #(.DRIVER_ON_CYCLES(20), .OFF_DELAY_CYCLES(20), .SETTLE_CYCLES(10))
		oled_power_init_sequencer_i (.clk(clk), .resetn(resetn), .power_up(power_up),
		.power_down(power_down), .vdd_en(vdd_en), .vcc_en(vcc_en),
		.panel_reset_low_n(panel_reset_low_n), .wr_n(wr_n), .dc(dc), .data(data),
		.ready(ready), .busy(busy));
	oled_panel_model oled_panel_model_i (.clk(clk), .vdd_en(vdd_en),
		.panel_reset_low_n(panel_reset_low_n), .wr_n(wr_n), .dc(dc), .data(data),
		.drivers_on(drivers_on));
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd
	task automatic check(input string what, input logic [8:0] exp, input logic [8:0] got);
		n_checks++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask : check
	task automatic tally_and_finish();
		if (failures == 0 && n_checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : tally_and_finish
	task automatic pulse(input bit up);
		@(negedge clk);
		if (up) power_up = 1'b1;
		else power_down = 1'b1;
		@(negedge clk);
		power_up = 1'b0;
		power_down = 1'b0;
	endtask : pulse
	task automatic wait_idle(input int lim);
		int n = 0;
		while (busy !== 1'b0 && n < lim) begin
			@(negedge clk);
			n++;
		end
		check("busy", 9'h0, 9'(busy));
	endtask : wait_idle
	task automatic expect_power_up();
		logic [7:0] init_b[20] = '{8'hAE, 8'hD5, 8'hA0, 8'hA8, 8'h3F, 8'hD3, 8'h00, 8'h40,
			8'hA1, 8'hC8, 8'hDA, 8'h12, 8'h81, 8'h80, 8'hD9, 8'h22, 8'hDB, 8'h3C, 8'hA4, 8'hA6};
		foreach (init_b[k]) exp_q.push_back({1'b0, init_b[k]});
		for (int p = 0; p < 8; p++) begin
			exp_q.push_back({1'b0, 8'hB0 + 8'(p)});
			exp_q.push_back(9'h000);
			exp_q.push_back(9'h010);
			repeat (128) exp_q.push_back(9'h100);
		end
		exp_q.push_back(9'h0AF);
	endtask : expect_power_up
	// the oldest note is taken whenever a strobe completes
	always @(posedge wr_n) if (resetn === 1'b1) begin
		if (exp_q.size() == 0) check("pending notes", 9'h1, 9'h0);
		else check("bus byte", exp_q.pop_front(), {dc, data});
	end
	initial begin
		#(20 * 40000);
		failures++;
		tally_and_finish();
	end
	initial begin
		repeat (12) @(posedge clk);
		@(negedge clk) resetn = 1'b1;
		repeat (rnd() % 8 + 1) pulse(1'b0);
		expect_power_up();
		pulse(1'b1);
		wait_idle(12000);
		check("ready", 9'h1, 9'(ready));
		check("drivers", 9'h1, 9'(drivers_on));
		check("reset pin", 9'h1, 9'(panel_reset_low_n));
		check("notes left", 9'h0, 9'(exp_q.size()));
		pulse(1'b1);
		exp_q.push_back(9'h0AE);
		pulse(1'b0);
		wait_idle(200);
		check("vcc_en", 9'h0, 9'(vcc_en));
		check("vdd_en", 9'h0, 9'(vdd_en));
		check("drivers", 9'h0, 9'(drivers_on));
		check("notes left", 9'h0, 9'(exp_q.size()));
		expect_power_up();
		pulse(1'b1);
		// power_down is refused until ready, so random levels here must change nothing
		repeat (rnd() % 4000 + 100) begin
			@(negedge clk);
			power_down = ^rnd();
		end
		@(negedge clk);
		resetn = 1'b0;
		power_down = 1'b0;
		exp_q.delete();
		@(negedge clk);
		check("vdd_en", 9'h0, 9'(vdd_en));
		check("vcc_en", 9'h0, 9'(vcc_en));
		check("reset pin", 9'h0, 9'(panel_reset_low_n));
		@(negedge clk) resetn = 1'b1;
		expect_power_up();
		pulse(1'b1);
		wait_idle(12000);
		check("ready", 9'h1, 9'(ready));
		check("drivers", 9'h1, 9'(drivers_on));
		check("notes left", 9'h0, 9'(exp_q.size()));
		tally_and_finish();
	end
endmodule : oled_power_init_sequencer_test
`default_nettype wire

// File: verif/oled_seq_props.sv
// concurrent checks on the sequencer's pins
`default_nettype none
module oled_seq_checker #(
	parameter int OFF_DELAY_CYCLES = 20
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic vdd_en,
	input wire logic vcc_en,
	input wire logic panel_reset_low_n,
	input wire logic wr_n,
	input wire logic dc,
	input wire logic [7:0] data,
	input wire logic ready
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] low_cnt_r;
	logic [15:0] off_cnt_r;
	logic [8:0] last_r;
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	// counters saturate so a long idle spell cannot wrap into a false pass
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			low_cnt_r <= '0;
			off_cnt_r <= '0;
			last_r <= '0;
		end else begin
			if (!vdd_en) low_cnt_r <= '0;
			else if (!panel_reset_low_n && low_cnt_r != 16'hFFFF) low_cnt_r <= low_cnt_r + 16'h1;
			if (vcc_en) off_cnt_r <= '0;
			else if (off_cnt_r != 16'hFFFF) off_cnt_r <= off_cnt_r + 16'h1;
			if ($fell(wr_n)) last_r <= {dc, data};
		end
	end
	a_reset_pulse_long: assert property ($rose(panel_reset_low_n) |-> low_cnt_r >= 16'h96)
		else $error("panel reset released early");
	a_panel_after_reset: assert property ($rose(vcc_en) |-> low_cnt_r >= 16'h96)
		else $error("panel supply on too soon");
	a_on_cmd_last: assert property ($rose(ready) |-> vcc_en && last_r == 9'h0AF)
		else $error("ready without display-on");
	a_off_before_vcc: assert property ($fell(vcc_en) |-> wr_n && last_r == 9'h0AE)
		else $error("panel supply off before display-off");
	a_logic_off_delay: assert property ($fell(vdd_en) |->
		off_cnt_r >= 16'((OFF_DELAY_CYCLES * 4) / 5))
		else $error("logic supply off too soon");
	a_vcc_needs_vdd: assert property (vcc_en |-> vdd_en)
		else $error("panel supply on without logic supply");
	a_bytes_powered: assert property ($fell(wr_n) |-> vdd_en && panel_reset_low_n)
		else $error("byte written in reset or unpowered");
	a_strobe_width: assert property ($fell(wr_n) |-> !wr_n [*4] ##1 wr_n)
		else $error("write strobe width wrong");
	a_bus_steady: assert property (!wr_n && !$fell(wr_n) |-> $stable(dc) && $stable(data))
		else $error("bus changed under strobe");
endmodule : oled_seq_checker
bind oled_power_init_sequencer oled_seq_checker #(.OFF_DELAY_CYCLES(OFF_DELAY_CYCLES))
	oled_seq_checker_i (.clk(clk), .resetn(resetn), .vdd_en(vdd_en), .vcc_en(vcc_en),
	.panel_reset_low_n(panel_reset_low_n), .wr_n(wr_n), .dc(dc), .data(data), .ready(ready));
`default_nettype wire
